//--- hw/pcrs_core.sv
// program counter, counter latches and hardware return stack of the cpu core
// assumes the sequencer gives one operation per clock and software accesses
// registers over a plain strobe port with read data one cycle later
//
// Notes on behaviour
// RULE1 - instruction counter is 21 bits held as low, high and upper bytes
// RULE2 - low byte is read/write; high byte loads only through high latch
// RULE3 - upper byte is not directly accessible; loads only through upper latch
// RULE4 - writing the low byte copies both latches into high and upper bytes
// RULE5 - reading the low byte copies high and upper bytes into latches
// RULE6 - bit 0 is always zero; sequential instructions advance by two
// RULE7 - calls, jumps and branches load the target, latches not used
// RULE8 - calls and interrupt acknowledges push the counter, up to 31 deep
// RULE9 - returns of every kind pop the stack into the counter
// RULE10 - call and return leave both latches unchanged
// RULE11 - stack is 31 by 21 bits, 5-bit pointer, apart from memories
// RULE12 - every reset zeroes the pointer; pointer zero has no entry
// RULE13 - push increments pointer first, then writes the selected entry
// RULE14 - pop moves selected entry to counter, then decrements pointer
// RULE15 - top-entry byte registers read and write the selected entry
// RULE16 - software reads and writes the pointer, values 0 through 31
// RULE17 - software masks interrupts while touching stack registers
// RULE18 - full flag sets after 31 pushes; cleared by software or power-on
// RULE19 - with overflow reset on, 31st push stores pc+2, flags, resets
// RULE20 - with overflow reset off, pointer sticks at 31, no overwrite
// RULE21 - pop at pointer zero sets underflow flag, pointer stays zero
`timescale 1ns/10ps
`default_nettype none
module pcrs_core #(
    parameter int PC_WIDTH = 21,
    parameter int DEPTH = 31
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset,
    input wire logic overflow_reset_enable,
    input wire pcrs_pkg::pcrs_op_e seq_op,
    input wire logic int_ack,
    input wire logic [20:0] jump_target,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [20:0] instr_counter,
    output logic stack_full_flag,
    output logic stack_underflow_flag,
    output logic overflow_reset_req
);
    import pcrs_pkg::*;

    // ======================================================================
    // state
    typedef struct packed {
        logic [20:0] pc;
        logic [7:0] high_latch;
        logic [4:0] upper_latch;
        logic [4:0] sp;
        logic full;
        logic under;
        logic ovf_req;
        logic [7:0] rdata;
    } pcrs_state_s;

    pcrs_state_s st;
    pcrs_state_s next_st;

    // ======================================================================
    // stack storage
    logic mem_we;
    logic [4:0] mem_widx;
    logic [20:0] mem_wdata;
    logic [20:0] top_entry;

    // flip-flop array kept apart from program and data space; see RULE11
    pcrs_stack_mem #(
        .WIDTH(PC_WIDTH),
        .DEPTH(DEPTH)
    ) u_stack (
        .clk(clk),
        .wr_en(mem_we),
        .wr_idx(mem_widx),
        .wr_data(mem_wdata),
        .rd_idx(st.sp),
        .rd_data(top_entry)
    );

    // ======================================================================
    // decoded strobes
    logic push;
    logic pop;
    logic wr_pcl;
    logic rd_pcl;
    logic [20:0] pc_seq;

    always_comb begin
        push = int_ack || seq_op == PCRS_OP_CALL; // see RULE8
        pop = !int_ack && seq_op == PCRS_OP_RETURN; // see RULE9
        wr_pcl = reg_wr && reg_addr == ADDR_PC_LOW;
        rd_pcl = reg_rd && reg_addr == ADDR_PC_LOW;
        pc_seq = st.pc + PC_STEP; // see RULE6
    end

    // ======================================================================
    // next state; calls, returns and jumps win over a software counter write in the
    // same cycle and the write wins over a step, which the core never issues together anyway
    always_comb begin
        next_st = st;
        next_st.ovf_req = 1'b0;
        mem_we = 1'b0;
        mem_widx = st.sp;
        mem_wdata = st.pc;

        // software register writes
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_PC_LOW: begin
                    // latches join the new low byte in one step; see RULE4
                    next_st.pc = {st.upper_latch, st.high_latch, reg_wdata[7:1], 1'b0};
                end
                ADDR_HIGH_LATCH: next_st.high_latch = reg_wdata; // see RULE2
                ADDR_UPPER_LATCH: next_st.upper_latch = reg_wdata[4:0]; // see RULE3
                ADDR_TOP_LOW: begin
                    mem_we = 1'b1; // see RULE15
                    mem_wdata = {top_entry[20:8], reg_wdata};
                end
                ADDR_TOP_HIGH: begin
                    mem_we = 1'b1; // see RULE15
                    mem_wdata = {top_entry[20:16], reg_wdata, top_entry[7:0]};
                end
                ADDR_TOP_UPPER: begin
                    mem_we = 1'b1; // see RULE15
                    mem_wdata = {reg_wdata[4:0], top_entry[15:0]};
                end
                ADDR_STACK_PTR: begin
                    // flags clear by writing zero; a hardware set below wins
                    next_st.sp = reg_wdata[4:0]; // see RULE16
                    next_st.full = st.full & reg_wdata[SPR_FULL_BIT]; // see RULE18
                    next_st.under = st.under & reg_wdata[SPR_UNDER_BIT]; // see RULE21
                end
                default: ;
            endcase
        end

        // reading the low byte snapshots the upper bytes; see RULE5
        if (rd_pcl) begin
            next_st.high_latch = st.pc[15:8];
            next_st.upper_latch = st.pc[20:16];
        end

        // sequencer; latches untouched on call and return, see RULE10
        if (push) begin
            if (st.sp == SP_TOP) begin
                // already full with reset off: no overwrite, pointer holds
                next_st.full = 1'b1; // see RULE20
                next_st.pc = {jump_target[20:1], 1'b0}; // see RULE6
            end else if (st.sp == SP_TOP - 5'h01 && overflow_reset_enable) begin
                // 31st push stores pc+2 and asks for a device reset; see RULE19
                mem_we = 1'b1;
                mem_widx = SP_TOP;
                mem_wdata = pc_seq;
                next_st.full = 1'b1;
                next_st.sp = SP_RESET;
                next_st.ovf_req = 1'b1;
                next_st.pc = PC_RESET;
            end else begin
                // increment first, then write the new slot; see RULE13
                mem_we = 1'b1;
                mem_widx = st.sp + 5'h01;
                mem_wdata = int_ack ? st.pc : pc_seq;
                next_st.sp = st.sp + 5'h01;
                if (st.sp == SP_TOP - 5'h01) begin
                    next_st.full = 1'b1; // see RULE18
                end
                next_st.pc = {jump_target[20:1], 1'b0}; // see RULE7 RULE6
            end
        end else if (pop) begin
            if (st.sp == SP_RESET) begin
                next_st.under = 1'b1; // see RULE21
                next_st.pc = PC_RESET;
            end else begin
                // entry first, then decrement; see RULE14
                next_st.pc = {top_entry[20:1], 1'b0};
                next_st.sp = st.sp - 5'h01;
            end
        end else if (seq_op == PCRS_OP_JUMP) begin
            next_st.pc = {jump_target[20:1], 1'b0}; // see RULE7
        end else if (seq_op == PCRS_OP_NEXT && !wr_pcl) begin
            next_st.pc = pc_seq; // see RULE6
        end

        // read data, valid the cycle after the strobe
        next_st.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_PC_LOW: next_st.rdata = st.pc[7:0];
                ADDR_HIGH_LATCH: next_st.rdata = st.high_latch;
                ADDR_UPPER_LATCH: next_st.rdata = {3'h0, st.upper_latch};
                ADDR_TOP_LOW: next_st.rdata = top_entry[7:0];
                ADDR_TOP_HIGH: next_st.rdata = top_entry[15:8];
                ADDR_TOP_UPPER: next_st.rdata = {3'h0, top_entry[20:16]};
                ADDR_STACK_PTR: next_st.rdata = {st.full, st.under, 1'b0, st.sp};
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ======================================================================
    // registers; flags survive ordinary resets, only power-on reset or a software write of zero clears them
    always_ff @(posedge clk) begin
        if (reset) begin
            st.pc <= PC_RESET;
            st.high_latch <= 8'h00;
            st.upper_latch <= 5'h00;
            st.sp <= SP_RESET; // see RULE12
            st.ovf_req <= 1'b0;
            st.rdata <= 8'h00;
            if (power_on_reset) begin
                st.full <= 1'b0; // see RULE18
                st.under <= 1'b0;
            end else begin
                st.full <= next_st.full;
                st.under <= next_st.under;
            end
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // outputs
    assign instr_counter = st.pc; // see RULE1
    assign stack_full_flag = st.full;
    assign stack_underflow_flag = st.under;
    assign overflow_reset_req = st.ovf_req;
    assign reg_rdata = st.rdata;
endmodule
`default_nettype wire

//--- hw/pcrs_pkg.sv
// program counter and return stack: shared constants, offsets and types
// assumes a single 50 MHz clock and a synchronous active-high reset
package pcrs_pkg;
    // ======================================================================
    // widths
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STACK_DEPTH = 31;
    // ======================================================================
    // register map, byte addresses on the plain register port
    localparam logic [3:0] ADDR_PC_LOW = 4'h0;
    localparam logic [3:0] ADDR_HIGH_LATCH = 4'h1;
    localparam logic [3:0] ADDR_UPPER_LATCH = 4'h2;
    localparam logic [3:0] ADDR_TOP_LOW = 4'h3;
    localparam logic [3:0] ADDR_TOP_HIGH = 4'h4;
    localparam logic [3:0] ADDR_TOP_UPPER = 4'h5;
    localparam logic [3:0] ADDR_STACK_PTR = 4'h6;
    // ======================================================================
    // stack pointer register fields
    localparam int SPR_FULL_BIT = 7;
    localparam int SPR_UNDER_BIT = 6;
    // ======================================================================
    // reset values and step
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [4:0] SP_RESET = 5'h00;
    localparam logic [4:0] SP_TOP = 5'h1f;
    localparam logic [20:0] PC_STEP = 21'h000002;
    // sequencer operations
    typedef enum logic [2:0] {
        PCRS_OP_NEXT,
        PCRS_OP_JUMP,
        PCRS_OP_CALL,
        PCRS_OP_RETURN,
        PCRS_OP_HOLD
    } pcrs_op_e;
endpackage

//--- hw/pcrs_stack_mem.sv
// return stack storage: flip-flop array of 31 entries
// assumes one write port and combinational read at the caller's index
`timescale 1ns/10ps
`default_nettype none
module pcrs_stack_mem #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 31
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [4:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [4:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    // ======================================================================
    // storage; slot i serves pointer value i+1, pointer zero has no entry
    logic [WIDTH-1:0] mem [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            // data path only; no reset needed on stored addresses
            always_ff @(posedge clk) begin
                if (wr_en && wr_idx == 5'(i + 1)) begin
                    mem[i] <= wr_data;
                end
            end
        end
    endgenerate

    // pointer zero reads as zero since nothing stands behind it
    always_comb begin
        if (rd_idx == 5'h00) begin
            rd_data = '0;
        end else begin
            rd_data = mem[rd_idx - 5'h01];
        end
    end
endmodule
`default_nettype wire

//--- test/pcrs_core_props.sv
// port checker for the counter and return stack core
// assumes it is bound to every pcrs_core instance
`timescale 1ns/10ps
`default_nettype none
module pcrs_core_props
    import pcrs_pkg::*;
#(parameter int PC_WIDTH = 21, parameter int DEPTH = 31) (
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset,
    input wire logic overflow_reset_enable,
    input wire pcrs_pkg::pcrs_op_e seq_op,
    input wire logic int_ack,
    input wire logic [20:0] jump_target,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [20:0] instr_counter,
    input wire logic stack_full_flag,
    input wire logic stack_underflow_flag,
    input wire logic overflow_reset_req
);
    // ====
    // properties, all on clk and held off during reset except the reset-state check
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire sp_wr = reg_wr && reg_addr == ADDR_STACK_PTR;
    AST_RESET_STATE: assert property (disable iff (1'b0) reset |=>
        instr_counter == PC_RESET && !overflow_reset_req) else $error("reset state wrong");
    AST_STEP: assert property (seq_op == PCRS_OP_NEXT && !int_ack |=>
        instr_counter == $past(instr_counter) + PC_STEP) else $error("step not two");
    AST_JUMP: assert property (seq_op == PCRS_OP_JUMP && !int_ack |=>
        instr_counter == {$past(jump_target[20:1]), 1'b0}) else $error("jump target lost");
    AST_CALL: assert property (seq_op == PCRS_OP_CALL && !int_ack |=> overflow_reset_req ||
        instr_counter == {$past(jump_target[20:1]), 1'b0}) else $error("call target lost");
    AST_ACK: assert property (int_ack |=> overflow_reset_req ||
        instr_counter == {$past(jump_target[20:1]), 1'b0}) else $error("vector not taken");
    AST_LOW_WRITE: assert property (reg_wr && reg_addr == ADDR_PC_LOW && seq_op == PCRS_OP_HOLD
        && !int_ack |=> instr_counter[7:0] == {$past(reg_wdata[7:1]), 1'b0}) else $error("low byte");
    AST_OVF_PULSE: assert property (overflow_reset_req |-> $past(overflow_reset_enable) &&
        stack_full_flag && instr_counter == PC_RESET ##1 !overflow_reset_req) else $error("ovf");
    AST_FULL_STICKY: assert property ($fell(stack_full_flag) |-> $past(power_on_reset) ||
        $past(sp_wr && !reg_wdata[SPR_FULL_BIT])) else $error("full flag dropped");
    AST_UNDER_STICKY: assert property ($fell(stack_underflow_flag) |-> $past(power_on_reset) ||
        $past(sp_wr && !reg_wdata[SPR_UNDER_BIT])) else $error("underflow flag dropped");
    cover property (overflow_reset_req);
    cover property (stack_full_flag && !overflow_reset_enable);
    cover property (stack_underflow_flag);
endmodule
bind pcrs_core pcrs_core_props #(.PC_WIDTH(PC_WIDTH), .DEPTH(DEPTH)) props (.clk(clk),
    .reset(reset), .power_on_reset(power_on_reset), .overflow_reset_enable(overflow_reset_enable),
    .seq_op(seq_op), .int_ack(int_ack), .jump_target(jump_target), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_counter(instr_counter), .stack_full_flag(stack_full_flag),
    .stack_underflow_flag(stack_underflow_flag), .overflow_reset_req(overflow_reset_req));
`default_nettype wire

//--- test/pcrs_seq_model.sv
// cpu sequencer stand-in: one operation per clock into the core
// assumes the bench never overlaps two calls of issue
`timescale 1ns/10ps
`default_nettype none
module pcrs_seq_model
    import pcrs_pkg::*;
(
    input wire logic clk,
    output pcrs_pkg::pcrs_op_e seq_op,
    output logic int_ack,
    output logic [20:0] jump_target
);
    // ====
    // idle until asked, so the counter only moves on purpose
    initial begin
        seq_op = PCRS_OP_HOLD;
        int_ack = 1'b0;
        jump_target = 21'h000000;
    end
    // acks only come between register accesses, never under them
    task automatic issue(input pcrs_op_e op, input logic ack, input logic [20:0] tgt);
        @(posedge clk);
        seq_op <= op;
        int_ack <= ack;
        jump_target <= tgt;
        @(posedge clk);
        seq_op <= PCRS_OP_HOLD;
        int_ack <= 1'b0;
        jump_target <= ~tgt; // stale target is not kept, so nothing leans on it
        #1;
    endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the counter and return stack core
// assumes the sequencer model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pcrs_pkg::*;
    logic clk = 1'b0, reset = 1'b1, power_on_reset = 1'b1, overflow_reset_enable = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, int_ack;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, u, h;
    logic [20:0] instr_counter, jump_target;
    logic stack_full_flag, stack_underflow_flag, overflow_reset_req;
    pcrs_op_e seq_op;
    int n_fail = 0, comparisons = 0;
    always #10 clk = ~clk;
    pcrs_seq_model seq (.clk(clk), .seq_op(seq_op), .int_ack(int_ack), .jump_target(jump_target));
    pcrs_core uut (.clk(clk), .reset(reset), .power_on_reset(power_on_reset),
        .overflow_reset_enable(overflow_reset_enable), .seq_op(seq_op), .int_ack(int_ack),
        .jump_target(jump_target), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_counter(instr_counter),
        .stack_full_flag(stack_full_flag), .stack_underflow_flag(stack_underflow_flag),
        .overflow_reset_req(overflow_reset_req));
    // ====
    // shared tasks
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one strobe cycle; read data stand only in the following cycle
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(reg_rdata, exp);
    endtask
    task automatic top_chk(input logic [20:0] exp);
        bus(1'b0, ADDR_TOP_UPPER, 8'h00);
        u = reg_rdata;
        bus(1'b0, ADDR_TOP_HIGH, 8'h00);
        h = reg_rdata;
        bus(1'b0, ADDR_TOP_LOW, 8'h00);
        check({u[4:0], h, reg_rdata}, exp);
    endtask
    task automatic do_reset(input logic por);
        @(posedge clk);
        reset <= 1'b1;
        power_on_reset <= por;
        @(posedge clk);
        reset <= 1'b0;
        power_on_reset <= 1'b0;
        #1;
    endtask
    task automatic final_report();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_counter_bytes();
        repeat (3) seq.issue(PCRS_OP_NEXT, 1'b0, 21'h000000);
        check(instr_counter, 21'h000006);
        bus(1'b1, ADDR_HIGH_LATCH, 8'h12);
        bus(1'b1, ADDR_UPPER_LATCH, 8'h03);
        bus(1'b1, ADDR_PC_LOW, 8'h35);
        check(instr_counter, 21'h031234);
        bus(1'b1, ADDR_HIGH_LATCH, 8'hff);
        bus(1'b1, ADDR_UPPER_LATCH, 8'h1f);
        rd_chk(ADDR_PC_LOW, 8'h34);
        bus(1'b1, ADDR_PC_LOW, 8'h00);
        check(instr_counter, 21'h031200);
    endtask
    task automatic t_call_return();
        bus(1'b1, ADDR_HIGH_LATCH, 8'h05);
        bus(1'b1, ADDR_UPPER_LATCH, 8'h01);
        seq.issue(PCRS_OP_JUMP, 1'b0, 21'h000100);
        check(instr_counter, 21'h000100);
        seq.issue(PCRS_OP_CALL, 1'b0, 21'h002000);
        check(instr_counter, 21'h002000);
        rd_chk(ADDR_STACK_PTR, 8'h01);
        top_chk(21'h000102);
        seq.issue(PCRS_OP_HOLD, 1'b1, 21'h000008);
        top_chk(21'h002000);
        seq.issue(PCRS_OP_RETURN, 1'b0, 21'h000000);
        check(instr_counter, 21'h002000);
        bus(1'b1, ADDR_TOP_LOW, 8'h40);
        seq.issue(PCRS_OP_RETURN, 1'b0, 21'h000000);
        check(instr_counter, 21'h000140);
        bus(1'b1, ADDR_PC_LOW, 8'h00);
        check(instr_counter, 21'h010500);
    endtask
    task automatic t_underflow();
        seq.issue(PCRS_OP_RETURN, 1'b0, 21'h000000);
        rd_chk(ADDR_STACK_PTR, 8'h40);
        bus(1'b1, ADDR_STACK_PTR, 8'h00);
        check(stack_underflow_flag, 1'b0);
        seq.issue(PCRS_OP_CALL, 1'b0, 21'h000301);
        check(instr_counter, 21'h000300);
        seq.issue(PCRS_OP_RETURN, 1'b0, 21'h000000);
        check(instr_counter, 21'h000002);
    endtask
    task automatic t_stack_full(input logic en);
        @(posedge clk);
        overflow_reset_enable <= en;
        seq.issue(PCRS_OP_JUMP, 1'b0, 21'h000200);
        repeat (31) seq.issue(PCRS_OP_CALL, 1'b0, 21'h000200);
        check(stack_full_flag, 1'b1);
        check(overflow_reset_req, en);
        if (en) begin
            check(instr_counter, PC_RESET);
            rd_chk(ADDR_STACK_PTR, 8'h80);
            bus(1'b1, ADDR_STACK_PTR, 8'h1f);
            top_chk(21'h000202);
            bus(1'b1, ADDR_STACK_PTR, 8'h00);
        end else begin
            seq.issue(PCRS_OP_JUMP, 1'b0, 21'h000300);
            seq.issue(PCRS_OP_CALL, 1'b0, 21'h000400);
            rd_chk(ADDR_STACK_PTR, 8'h9f);
            top_chk(21'h000202);
            do_reset(1'b0);
            rd_chk(ADDR_STACK_PTR, 8'h80);
            do_reset(1'b1);
            rd_chk(ADDR_STACK_PTR, 8'h00);
        end
    endtask
    // ====
    // main sequence and hang guard
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        power_on_reset <= 1'b0;
        rd_chk(ADDR_STACK_PTR, 8'h00);
        rd_chk(4'h7, 8'h00);
        t_counter_bytes();
        t_call_return();
        t_underflow();
        t_stack_full(1'b0);
        t_stack_full(1'b1);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
